//--- design/dcc_pkg.sv
// Package for the dual capture/compare block
// Assumes a single 200 MHz system clock and an APB register slave
package dcc_pkg;

    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam logic [7:0] DCC_ADDR_MODE_CTRL = 8'h00;
    localparam logic [7:0] DCC_ADDR_FLAGS     = 8'h04;
    localparam logic [7:0] DCC_ADDR_VAL_ONE   = 8'h08;
    localparam logic [7:0] DCC_ADDR_VAL_TWO   = 8'h0C;
    localparam logic [7:0] DCC_ADDR_TIMER_CFG = 8'h10;
    localparam logic [7:0] DCC_ADDR_PORT      = 8'h14;
    localparam logic [7:0] DCC_ADDR_TIMER     = 8'h18;

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int DCC_SET_ONE_LSB = 0;
    localparam int DCC_SET_TWO_LSB = 4;
    localparam int DCC_FLAG_OVF    = 0;
    localparam int DCC_FLAG_ONE    = 2;
    localparam int DCC_FLAG_TWO    = 3;
    localparam logic [7:0]  DCC_MODE_RESET = 8'h00;
    localparam logic [15:0] DCC_WORD_ZERO  = 16'h0000;
    localparam logic [15:0] DCC_TIMER_MAX  = 16'hFFFF;

    // ****************************************
    // Timing
    // ****************************************
    localparam int SYS_CLK_MHZ   = 200;
    localparam int INSTR_CLK_MHZ = 2;
    localparam int SYS_OSC_MHZ   = 8;
    localparam int INSTR_DIV     = SYS_CLK_MHZ / INSTR_CLK_MHZ;
    localparam int OSC_DIV       = SYS_CLK_MHZ / SYS_OSC_MHZ;
    localparam int DIV_W         = 7;
    localparam int PRESC_W       = 4;
    localparam logic [3:0] PRESC_FOUR    = 4'h3;
    localparam logic [3:0] PRESC_SIXTEEN = 4'hF;

    // ****************************************
    // Mode codes
    // ****************************************
    typedef enum logic [3:0] {
        DCC_CAP_FALL   = 4'b0100,
        DCC_CAP_RISE   = 4'b0101,
        DCC_CAP_RISE4  = 4'b0110,
        DCC_CAP_RISE16 = 4'b0111,
        DCC_CMP_SET    = 4'b1000,
        DCC_CMP_CLEAR  = 4'b1001,
        DCC_CMP_TOGGLE = 4'b1010,
        DCC_CMP_RSVD   = 4'b1011,
        DCC_CMP_SOFT0  = 4'b1100,
        DCC_CMP_SOFT1  = 4'b1101,
        DCC_CMP_SOFT2  = 4'b1110,
        DCC_CMP_TRIG   = 4'b1111
    } dcc_mode_t;

    // Result of one register set for one cycle
    typedef struct packed {
        logic        event_pulse;
        logic        trigger_pulse;
        logic        out_latch;
        logic [15:0] value;
    } dcc_set_status_t;

endpackage : dcc_pkg

//--- design/dcc_set.sv
// One capture/compare register set
// Assumes pin level and timer count synchronous to sys_clk_in
`timescale 1ns/1ps
module dcc_set
    import dcc_pkg::*;
(
    input  wire logic            sys_clk_in,
    input  wire logic            resetn_in,
    input  wire logic [3:0]      mode_in,
    input  wire logic            pin_in,
    input  wire logic [15:0]     timer_in,
    input  wire logic            val_wr_in,
    input  wire logic [15:0]     val_wdata_in,
    output dcc_set_status_t      status_out
);

    // ****************************************
    // State
    // ****************************************
    logic               pin_q;
    logic [PRESC_W-1:0] presc;
    logic [15:0]        value;
    logic               out_latch;
    logic               match_q;
    logic               prev_clear;
    logic [PRESC_W-1:0] next_presc;
    logic [15:0]        next_value;
    logic               next_out_latch;
    logic               next_match_q;
    logic               next_prev_clear;
    logic               ev;
    logic               trig;
    logic               is_off;
    logic               is_cap;
    logic               is_cmp;
    logic               rise;
    logic               fall;
    logic               match;

    always_comb begin
        is_off         = (mode_in[3:2] == 2'b00);
        is_cap         = (mode_in[3:2] == 2'b01);
        is_cmp         = mode_in[3];
        rise           = pin_in & ~pin_q;
        fall           = ~pin_in & pin_q;
        match          = is_cmp & (timer_in == value);
        next_presc     = presc;
        next_value     = val_wr_in ? val_wdata_in : value;
        next_out_latch = out_latch;
        next_match_q   = match;
        next_prev_clear = (mode_in == 4'(DCC_CMP_CLEAR));
        ev             = 1'b0;
        trig           = 1'b0;
        if (is_off) begin
            next_presc     = '0; // R7
            next_match_q   = 1'b0; // R6
            // Off-code default of the output latch differs for clear-on-match
            next_prev_clear = prev_clear;
            next_out_latch  = prev_clear; // R19
        end else if (is_cap) begin
            case (mode_in)
                DCC_CAP_FALL:   ev = fall; // R2
                DCC_CAP_RISE:   ev = rise; // R2
                DCC_CAP_RISE4: begin
                    if (rise) begin
                        next_presc = presc + 1'b1; // R8
                        ev = (presc[1:0] == PRESC_FOUR[1:0]); // R2
                    end
                end
                default: begin
                    if (rise) begin
                        next_presc = presc + 1'b1;
                        ev = (presc == PRESC_SIXTEEN); // R2
                    end
                end
            endcase
            if (ev) begin
                next_value = timer_in; // R1 R5
            end
        end else begin
            next_presc = '0; // R7
            if (match && !match_q) begin // R14 R21
                case (mode_in)
                    DCC_CMP_SET:    begin next_out_latch = 1'b1; ev = 1'b1; end
                    DCC_CMP_CLEAR:  begin next_out_latch = 1'b0; ev = 1'b1; end
                    DCC_CMP_TOGGLE: begin
                        next_out_latch = ~out_latch; // R15
                        ev = 1'b1;
                    end
                    DCC_CMP_RSVD:   ev = 1'b0;
                    DCC_CMP_TRIG:   begin ev = 1'b1; trig = 1'b1; end // R17
                    default:        ev = 1'b1; // R16
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pin_q      <= 1'b0;
            presc      <= '0;
            value      <= DCC_WORD_ZERO;
            out_latch  <= 1'b0;
            match_q    <= 1'b0;
            prev_clear <= 1'b0;
        end else begin
            pin_q      <= pin_in;
            presc      <= next_presc;
            value      <= next_value;
            match_q    <= next_match_q;
            prev_clear <= next_prev_clear;
            out_latch  <= next_out_latch;
        end
    end

    assign status_out = '{event_pulse: ev, trigger_pulse: trig,
                          out_latch: out_latch, value: value};

endmodule : dcc_set

//--- design/dcc_top.sv
// Dual capture/compare block with shared 16-bit timer and APB slave
// Assumes one 200 MHz clock; APB master follows the usual protocol
//
// Summary of operation
// R1: Capture copies the full 16-bit timer count into the set value.
// R2: Codes 0100/0101/0110/0111 capture falling, rising, 4th, 16th rising.
// R3: Set one mode in control bits 3:0, set two in bits 7:4.
// R4: Capture sets flag bit 2 or 3; it stays until software clears.
// R5: A new capture overwrites the old value with no overrun sign.
// R6: Codes 00xx switch the set off and reset its logic.
// R7: Prescaler counter cleared when off, not capturing, or on reset.
// R8: Changing prescaler directly keeps the counter; flag may set.
// R9: Software should write an off code before changing the prescaler.
// R10: Software masks the interrupt during mode change and clears flag.
// R11: Software sets pin directions for capture input and compare output.
// R12: Port latch write on an output capture pin can trigger capture.
// R13: Software clocks the timer from the instruction clock.
// R14: Compare mode compares compare value with timer count continuously.
// R15: 1000 sets, 1001 clears, 1010 toggles output; flag set; 1011 reserved.
// R16: Codes 1100/1101/1110 only set the flag; pin stays under GPIO control.
// R17: Code 1111 sets flag and pulses converter trigger; timer not reset.
// R18: The special event never sets the timer overflow flag.
// R19: Off code loads output latch default: 0, or 1 for clear mode.
// R20: Timer ticks at 2 MHz or 8 MHz as the clock select bit says.
// R21: A match fires once when equality first appears.
`timescale 1ns/1ps
module dcc_top
    import dcc_pkg::*;
(
    input  wire logic        sys_clk_in,
    input  wire logic        resetn_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic [31:0]      prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    input  wire logic        capture_input_pin_in,
    output logic             capture_input_pin_out,
    output logic             capture_input_pin_oe_out,
    output logic             compare_output_pin_one_out,
    output logic             compare_output_pin_two_out,
    output logic             adc_trigger_out,
    output logic [15:0]      timer_count_out
);

    // ****************************************
    // Registers
    // ****************************************
    logic [7:0]  mode_ctrl;
    logic [3:0]  flags;
    logic        timer_on;
    logic        timer_clock_select;
    logic [2:0]  port_ctrl;
    logic [15:0] timer;
    logic [DIV_W-1:0] div_cnt;
    logic [31:0] rdata;
    logic        ready;
    logic        slverr;
    logic        trig_q;
    logic        cmp_one_q;
    logic        cmp_two_q;
    logic        pin_oe_q;
    logic        pin_o_q;

    logic [7:0]  next_mode_ctrl;
    logic [3:0]  next_flags;
    logic        next_timer_on;
    logic        next_timer_clock_select;
    logic [2:0]  next_port_ctrl;
    logic [15:0] next_timer;
    logic [DIV_W-1:0] next_div_cnt;
    logic [31:0] next_rdata;
    logic        next_ready;
    logic        next_slverr;

    logic        access;
    logic        wr;
    logic        tick;
    logic        pin_level;
    logic [1:0]  val_wr;
    dcc_set_status_t st [2];

    // ****************************************
    // Register sets
    // ****************************************
    // Pin seen by capture is the port latch when the pin drives
    always_comb begin
        pin_level = port_ctrl[0] ? port_ctrl[1] : capture_input_pin_in; // R12
    end

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_set
            dcc_set u_set (
                .sys_clk_in   (sys_clk_in),
                .resetn_in    (resetn_in),
                .mode_in      (mode_ctrl[g*4 +: 4]), // R3
                .pin_in       (pin_level),
                .timer_in     (timer),
                .val_wr_in    (val_wr[g]),
                .val_wdata_in (pwdata_in[15:0]),
                .status_out   (st[g])
            );
        end
    endgenerate

    // ****************************************
    // Bus, flags and timer
    // ****************************************
    always_comb begin
        access = psel_in & penable_in & ~ready;
        wr     = access & pwrite_in;
        val_wr[0] = wr & (paddr_in == DCC_ADDR_VAL_ONE);
        val_wr[1] = wr & (paddr_in == DCC_ADDR_VAL_TWO);
        next_mode_ctrl          = mode_ctrl;
        next_flags              = flags;
        next_timer_on           = timer_on;
        next_timer_clock_select = timer_clock_select;
        next_port_ctrl          = port_ctrl;
        next_rdata              = rdata;
        next_ready              = access;
        next_slverr             = 1'b0;
        // Timer rate select
        tick = 1'b0;
        next_div_cnt = div_cnt + 1'b1;
        if (timer_clock_select) begin
            if (div_cnt >= DIV_W'(OSC_DIV - 1)) begin // R20
                next_div_cnt = '0;
                tick = 1'b1;
            end
        end else if (div_cnt >= DIV_W'(INSTR_DIV - 1)) begin // R20
            next_div_cnt = '0;
            tick = 1'b1;
        end
        next_timer = (timer_on && tick) ? timer + 1'b1 : timer;
        if (access) begin
            case (paddr_in)
                DCC_ADDR_MODE_CTRL: begin
                    next_rdata = {24'h0000_00, mode_ctrl};
                    if (pwrite_in) begin
                        next_mode_ctrl = pwdata_in[7:0];
                    end
                end
                DCC_ADDR_FLAGS: begin
                    next_rdata = {28'h000_0000, flags};
                    if (pwrite_in) begin
                        next_flags = pwdata_in[3:0];
                    end
                end
                DCC_ADDR_VAL_ONE: next_rdata = {16'h0000, st[0].value};
                DCC_ADDR_VAL_TWO: next_rdata = {16'h0000, st[1].value};
                DCC_ADDR_TIMER_CFG: begin
                    next_rdata = {30'h0000_0000, timer_clock_select,
                                  timer_on};
                    if (pwrite_in) begin
                        next_timer_on           = pwdata_in[0];
                        next_timer_clock_select = pwdata_in[1];
                    end
                end
                DCC_ADDR_PORT: begin
                    next_rdata = {29'h0000_0000, port_ctrl};
                    if (pwrite_in) begin
                        next_port_ctrl = pwdata_in[2:0];
                    end
                end
                DCC_ADDR_TIMER: begin
                    next_rdata = {16'h0000, timer};
                    if (pwrite_in) begin
                        next_timer = pwdata_in[15:0];
                    end
                end
                default: begin
                    next_rdata  = 32'h0000_0000;
                    next_slverr = 1'b1;
                end
            endcase
        end
        // Hardware set wins over software clear
        if (timer_on && tick && timer == DCC_TIMER_MAX) begin
            next_flags[DCC_FLAG_OVF] = 1'b1; // R18
        end
        if (st[0].event_pulse) begin
            next_flags[DCC_FLAG_ONE] = 1'b1; // R4
        end
        if (st[1].event_pulse) begin
            next_flags[DCC_FLAG_TWO] = 1'b1; // R4
        end
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            mode_ctrl          <= DCC_MODE_RESET;
            flags              <= '0;
            timer_on           <= 1'b0;
            timer_clock_select <= 1'b0;
            port_ctrl          <= '0;
            timer              <= DCC_WORD_ZERO;
            div_cnt            <= '0;
            rdata              <= '0;
            ready              <= 1'b0;
            slverr             <= 1'b0;
            trig_q             <= 1'b0;
            cmp_one_q          <= 1'b0;
            cmp_two_q          <= 1'b0;
            pin_oe_q           <= 1'b0;
            pin_o_q            <= 1'b0;
        end else begin
            mode_ctrl          <= next_mode_ctrl;
            flags              <= next_flags;
            timer_on           <= next_timer_on;
            timer_clock_select <= next_timer_clock_select;
            port_ctrl          <= next_port_ctrl;
            timer              <= next_timer; // R17
            div_cnt            <= next_div_cnt;
            rdata              <= next_rdata;
            ready              <= next_ready;
            slverr             <= next_slverr;
            trig_q             <= st[0].trigger_pulse | st[1].trigger_pulse;
            cmp_one_q          <= st[0].out_latch;
            cmp_two_q          <= st[1].out_latch;
            pin_oe_q           <= port_ctrl[0];
            pin_o_q            <= port_ctrl[1];
        end
    end

    always_comb begin
        prdata_out                 = rdata;
        pready_out                 = ready;
        pslverr_out                = slverr;
        adc_trigger_out            = trig_q;
        compare_output_pin_one_out = cmp_one_q;
        compare_output_pin_two_out = cmp_two_q;
        capture_input_pin_oe_out   = pin_oe_q;
        capture_input_pin_out      = pin_o_q;
        timer_count_out            = timer;
    end

    // ****************************************
    // Checks
    // ****************************************
    sequence s_trig_match;
        mode_ctrl[3:0] == 4'b1111 && st[0].trigger_pulse;
    endsequence

    property p_trig_flag;
        @(posedge sys_clk_in) disable iff (!resetn_in)
        s_trig_match |=> flags[DCC_FLAG_ONE] && adc_trigger_out;
    endproperty
    a_trig_flag: assert property (p_trig_flag) // R17
        else $error("Trigger did not set flag and pulse");

    property p_flag_sticky;
        @(posedge sys_clk_in) disable iff (!resetn_in)
        flags[DCC_FLAG_TWO] && !wr |=> flags[DCC_FLAG_TWO];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) // R4
        else $error("Flag cleared without software");

    property p_no_ovf;
        @(posedge sys_clk_in) disable iff (!resetn_in)
        !flags[DCC_FLAG_OVF] && !wr && timer != DCC_TIMER_MAX
            |=> !flags[DCC_FLAG_OVF];
    endproperty
    a_no_ovf: assert property (p_no_ovf) // R18
        else $error("Overflow flag set by special event");

    property p_off_quiet;
        @(posedge sys_clk_in) disable iff (!resetn_in)
        mode_ctrl[3:2] == 2'b00 |-> !st[0].event_pulse;
    endproperty
    a_off_quiet: assert property (p_off_quiet) // R6
        else $error("Event while set is off");

    property p_single_match;
        @(posedge sys_clk_in) disable iff (!resetn_in)
        st[1].event_pulse && mode_ctrl[7] |=> !st[1].event_pulse;
    endproperty
    a_single_match: assert property (p_single_match) // R21
        else $error("Match fired twice in a row");

    property p_soft_pin;
        @(posedge sys_clk_in) disable iff (!resetn_in)
        mode_ctrl[3:2] == 2'b11 && $stable(mode_ctrl) ##1
            mode_ctrl[3:2] == 2'b11 |-> $stable(st[0].out_latch);
    endproperty
    a_soft_pin: assert property (p_soft_pin) // R16
        else $error("Output latch moved in software mode");

    property p_capture;
        @(posedge sys_clk_in) disable iff (!resetn_in)
        mode_ctrl[3:2] == 2'b01 && st[0].event_pulse
            |=> st[0].value == $past(timer);
    endproperty
    a_capture: assert property (p_capture) // R1
        else $error("Captured value differs from timer");

    property p_ready_once;
        @(posedge sys_clk_in) disable iff (!resetn_in)
        pready_out |=> !pready_out;
    endproperty
    a_ready_once: assert property (p_ready_once)
        else $error("Ready held beyond one cycle");

endmodule : dcc_top

//--- verif/dcc_far_side.sv
// Far-side model: external capture pin driver and converter trigger counter
// Assumes the bench sets the external pin level through drive_level_in
`timescale 1ns/1ps
module dcc_far_side (
    input  wire logic sys_clk_in,
    input  wire logic resetn_in,
    input  wire logic drive_level_in,
    input  wire logic pin_out_in,
    input  wire logic pin_oe_in,
    input  wire logic adc_trigger_in,
    output logic      pin_level_out,
    output int        trig_count_out
);
    // Device drives the pin only while its enable is high
    assign pin_level_out = pin_oe_in ? pin_out_in : drive_level_in;
    // Converter counts each start pulse
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            trig_count_out <= 0;
        end else if (adc_trigger_in === 1'b1) begin
            trig_count_out <= trig_count_out + 1;
        end
    end
endmodule : dcc_far_side

//--- verif/dual_capture_compare_unit_bench.sv
// Bench for the dual capture/compare block: APB driver and reference model
// Assumes the dcc_pkg register map and the far-side model dcc_far_side
`timescale 1ns/1ps
module dual_capture_compare_unit_bench;
    import dcc_pkg::*;
    logic        sys_clk_in, resetn_in, psel, penable, pwrite, ext_lvl;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic        pready, pslverr, pin_lvl, pin_q, pin_oe, adc, err;
    logic [1:0]  cmp;
    logic [15:0] tmr;
    int          errors, n_tests, m_flags, trig_cnt, m_trig, t;
    int          m_latch[2];
    int          prev_mode[2];
    int          codes[8] = '{8, 10, 9, 9, 15, 12, 13, 14};

    dcc_top dut_u (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
        .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr),
        .capture_input_pin_in(pin_lvl), .capture_input_pin_out(pin_q),
        .capture_input_pin_oe_out(pin_oe),
        .compare_output_pin_one_out(cmp[0]),
        .compare_output_pin_two_out(cmp[1]),
        .adc_trigger_out(adc), .timer_count_out(tmr));
    dcc_far_side far_u (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
        .drive_level_in(ext_lvl), .pin_out_in(pin_q), .pin_oe_in(pin_oe),
        .adc_trigger_in(adc), .pin_level_out(pin_lvl),
        .trig_count_out(trig_cnt));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk_in);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk_in);
            n++;
        end while (pready !== 1'b1 && n < 40);
        q = prdata;
        err = pslverr;
        if (n >= 40) errors++;
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (2) @(posedge sys_clk_in);
    endtask : apb

    task automatic pin(input logic lvl);
        ext_lvl <= lvl;
        repeat (4) @(posedge sys_clk_in);
    endtask : pin

    task automatic cap_test(input int s, input int code);
        int n;
        n = (code == 6) ? 4 : (code == 7) ? 16 : 1;
        apb(1, DCC_ADDR_MODE_CTRL, 0);
        t = $urandom_range(16'hFFFF);
        apb(1, DCC_ADDR_TIMER, t);
        chk("timer out", tmr, t);
        apb(1, DCC_ADDR_MODE_CTRL, code << (4 * s));
        apb(1, DCC_ADDR_FLAGS, 0);
        m_flags = 1 << (DCC_FLAG_ONE + s);
        repeat (n - 1) begin
            pin(1);
            pin(0);
        end
        apb(0, DCC_ADDR_FLAGS, 0);
        chk("pre flag", q, 0);
        pin(1);
        apb(0, DCC_ADDR_FLAGS, 0);
        chk("rise flag", q, (code == 4) ? 0 : m_flags);
        pin(0);
        apb(0, DCC_ADDR_FLAGS, 0);
        chk("flag", q, m_flags);
        apb(0, 8'(DCC_ADDR_VAL_ONE + 4 * s), 0);
        chk("capture", q, t);
        t = $urandom_range(16'hFFFF);
        apb(1, DCC_ADDR_TIMER, t);
        repeat (n) begin
            pin(1);
            pin(0);
        end
        apb(0, 8'(DCC_ADDR_VAL_ONE + 4 * s), 0);
        chk("overwrite", q, t);
    endtask : cap_test

    task automatic cmp_test(input int s);
        int c;
        c = 16'h0100 + $urandom_range(16'hF000);
        apb(1, 8'(DCC_ADDR_VAL_ONE + 4 * s), c);
        foreach (codes[i]) begin
            apb(1, DCC_ADDR_MODE_CTRL, 0);
            m_latch[s] = (prev_mode[s] == 9) ? 1 : 0;
            chk("default", cmp[s], m_latch[s]);
            apb(1, DCC_ADDR_FLAGS, 0);
            apb(1, DCC_ADDR_TIMER, c - 1);
            apb(1, DCC_ADDR_MODE_CTRL, codes[i] << (4 * s));
            apb(1, DCC_ADDR_TIMER_CFG, 1);
            repeat (110) @(posedge sys_clk_in);
            apb(1, DCC_ADDR_TIMER_CFG, 0);
            m_flags = 1 << (DCC_FLAG_ONE + s);
            if (codes[i] == 8) m_latch[s] = 1;
            if (codes[i] == 9) m_latch[s] = 0;
            if (codes[i] == 10) m_latch[s] = 1 - m_latch[s];
            if (codes[i] == 15) m_trig++;
            prev_mode[s] = codes[i];
            chk("pin", cmp[s], m_latch[s]);
            chk("trigger", trig_cnt, m_trig);
            apb(0, DCC_ADDR_FLAGS, 0);
            chk("flags", q, m_flags);
            apb(0, DCC_ADDR_TIMER, 0);
            chk("no reset", q >= c, 1);
            apb(1, DCC_ADDR_FLAGS, 0);
            repeat (20) @(posedge sys_clk_in);
            apb(0, DCC_ADDR_FLAGS, 0);
            chk("once", q, 0);
        end
    endtask : cmp_test

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish

    // ****************************************
    // Clock, watchdog and tests
    // ****************************************
    initial begin
        sys_clk_in = 1'b0;
        forever #2.5 sys_clk_in = ~sys_clk_in;
    end

    initial begin
        repeat (80000) @(posedge sys_clk_in);
        errors++;
        tally_and_finish;
    end

    initial begin
        {resetn_in, psel, penable, pwrite, ext_lvl} = 5'b0_0000;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        errors = 0;
        n_tests = 0;
        m_trig = 0;
        prev_mode = '{0, 0};
        void'($urandom(66));
        repeat (16) @(posedge sys_clk_in);
        resetn_in <= 1'b1;
        @(posedge sys_clk_in);
        apb(0, DCC_ADDR_MODE_CTRL, 0);
        chk("mode reset", q, DCC_MODE_RESET);
        apb(0, DCC_ADDR_FLAGS, 0);
        chk("flags reset", q, 0);
        apb(0, 8'h1C, 0);
        chk("slverr", err, 1);
        chk("unmapped", q, 0);
        t = $urandom_range(255);
        apb(1, DCC_ADDR_MODE_CTRL, t);
        apb(0, DCC_ADDR_MODE_CTRL, 0);
        chk("mode rw", q, t);
        m_trig = ((t & 15) == 15 || (t >> 4) == 15) ? 1 : 0;
        chk("rw trigger", trig_cnt, m_trig);
        $display("test registers done");
        for (int s = 0; s < 2; s++) begin
            for (int k = 4; k < 8; k++) cap_test(s, k);
        end
        $display("test capture done");
        apb(1, DCC_ADDR_MODE_CTRL, 5);
        apb(1, DCC_ADDR_PORT, 1);
        apb(1, DCC_ADDR_FLAGS, 0);
        chk("pin drive", pin_oe, 1);
        apb(1, DCC_ADDR_PORT, 3);
        apb(0, DCC_ADDR_FLAGS, 0);
        chk("port capture", q, 1 << DCC_FLAG_ONE);
        chk("pin latch", pin_q, 1);
        apb(1, DCC_ADDR_PORT, 0);
        apb(1, DCC_ADDR_MODE_CTRL, 0);
        apb(1, DCC_ADDR_MODE_CTRL, 7);
        repeat (3) begin
            pin(1);
            pin(0);
        end
        apb(1, DCC_ADDR_MODE_CTRL, 6);
        apb(1, DCC_ADDR_FLAGS, 0);
        pin(1);
        pin(0);
        apb(0, DCC_ADDR_FLAGS, 0);
        chk("presc kept", q, 1 << DCC_FLAG_ONE);
        $display("test port write done");
        cmp_test(0);
        cmp_test(1);
        $display("test compare done");
        for (int k = 0; k < 2; k++) begin
            t = 1000 / (k ? OSC_DIV : INSTR_DIV);
            apb(1, DCC_ADDR_TIMER, 0);
            apb(1, DCC_ADDR_TIMER_CFG, 1 + 2 * k);
            repeat (1000) @(posedge sys_clk_in);
            apb(1, DCC_ADDR_TIMER_CFG, 0);
            apb(0, DCC_ADDR_TIMER, 0);
            chk("rate", q >= t - 1 && q <= t + 1, 1);
        end
        $display("test timer rate done");
        tally_and_finish;
    end
endmodule : dual_capture_compare_unit_bench
